// File: pkg/capability_pkg.sv
// Constants for the far-end capability register bank
package capability_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] PORT_SELECT_ADDR = 8'h1e;
	localparam logic [7:0] CAP1_ADDR = 8'h20;
	localparam logic [7:0] CAP2_ADDR = 8'h21;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FREEZE_BIT = 7;
	localparam int MODE_LOW_BIT = 6;
	localparam int FREQ_BIT = 5;
	localparam int EQ_BIT = 4;
	localparam int TWO_LANE_BIT = 3;
	localparam int ROLE_BIT = 2;
	localparam int SECOND_PORT_BIT = 1;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int PORT_COUNT = 2;
	localparam int CAP1_WIDTH = 8;
	localparam int CAP2_WIDTH = 2;
	localparam int BC_WIDTH = 7;
	localparam int SELECT_WIDTH = 2;
	localparam int MODE_WIDTH = 3;
	localparam logic [7:0] CAP1_RESET = 8'h00;
	localparam logic [1:0] CAP2_RESET = 2'h0;
	localparam logic [1:0] SELECT_RESET = 2'h1;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
	localparam logic [5:0] CAP2_PAD = 6'h00;
	localparam logic [5:0] SELECT_PAD = 6'h00;

endpackage

// File: pkg/cap_if.sv
// Link between the register front end and one port's capability store
`timescale 1ns/100ps
interface cap_if;
	import capability_pkg::*;
	logic wr1;
	logic wr2;
	logic [CAP1_WIDTH-1:0] wdata;
	logic bc_load;
	logic [BC_WIDTH-1:0] bc_cap1;
	logic [CAP2_WIDTH-1:0] bc_cap2;
	logic [CAP1_WIDTH-1:0] cap1;
	logic [CAP2_WIDTH-1:0] cap2;

	modport ctrl (
		output wr1,
		output wr2,
		output wdata,
		output bc_load,
		output bc_cap1,
		output bc_cap2,
		input cap1,
		input cap2
	);

	modport store (
		input wr1,
		input wr2,
		input wdata,
		input bc_load,
		input bc_cap1,
		input bc_cap2,
		output cap1,
		output cap2
	);
endinterface

// File: logic/capability_store.sv
// Capability flags of one port, loaded by back channel or by software
`timescale 1ns/100ps
module capability_store
	import capability_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Front end link
	cap_if.store link
);

	logic [CAP1_WIDTH-1:0] cap1;
	logic [CAP2_WIDTH-1:0] cap2;
	logic [CAP1_WIDTH-1:0] next_cap1;
	logic [CAP2_WIDTH-1:0] next_cap2;

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	// Back channel load unless frozen; a software write overrides it
	always_comb
	begin
		next_cap1 = cap1;
		next_cap2 = cap2;
		if (link.bc_load && !cap1[FREEZE_BIT]) // [R1] [R3]
		begin
			next_cap1[BC_WIDTH-1:0] = link.bc_cap1; // Freeze bit is software only
			next_cap2 = link.bc_cap2; // [R2]
		end
		if (link.wr1)
			next_cap1 = link.wdata;
		if (link.wr2)
			next_cap2 = link.wdata[CAP2_WIDTH-1:0];
	end

	// Register the flags
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cap1 <= CAP1_RESET;
			cap2 <= CAP2_RESET;
		end
		else
		begin
			cap1 <= next_cap1;
			cap2 <= next_cap2;
		end
	end

	assign link.cap1 = cap1;
	assign link.cap2 = cap2;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_freeze_holds_flags: assert property ( // [R1]
		@(posedge core_clk) disable iff (rst)
		(link.bc_load && cap1[FREEZE_BIT] && !link.wr1 && !link.wr2)
		|=> (cap1 == $past(cap1)) && (cap2 == $past(cap2)))
		else $error("Frozen flags changed by back channel");

	a_back_channel_load: assert property ( // [R3]
		@(posedge core_clk) disable iff (rst)
		(link.bc_load && !cap1[FREEZE_BIT] && !link.wr1)
		|=> (cap1[BC_WIDTH-1:0] == $past(link.bc_cap1)) && !cap1[FREEZE_BIT])
		else $error("Back channel load not taken");

	a_mode_upper_load: assert property ( // [R2]
		@(posedge core_clk) disable iff (rst)
		(link.bc_load && !cap1[FREEZE_BIT] && !link.wr2)
		|=> cap2 == $past(link.bc_cap2))
		else $error("Upper mode bits not loaded");

	a_software_write: assert property ( // [R11]
		@(posedge core_clk) disable iff (rst)
		link.wr1 |=> cap1 == $past(link.wdata))
		else $error("Software write not stored");

endmodule

// File: logic/far_end_capability_register.sv
// Per-port far-end capability register with port select and read path
`timescale 1ns/100ps
// Behaviour
// R1: Freeze bit 7 stops back channel loading; software values stay in both registers.
// R2: Bit 6 holds mode code bit 0; upper two bits sit in register 0x21.
// R3: After receiver lock, back channel updates every field but the freeze bit unless frozen.
// R4: Software overwriting a field must also set freeze, else it may be replaced.
// R5: Bit 5 requests frequency training pattern on the forward link.
// R6: Bit 4 requests equalization training pattern on the forward link.
// R7: Bit 3 reports far-end two-lane capability.
// R8: Bit 2 gives channel role: 0 primary, 1 secondary.
// R9: Each port has its own copy; second port select picks the second copy.
// R10: Select bit routes primary accesses to port two; clear it for port one.
// R11: A read returns each field's current value, whoever set it.
module far_end_capability_register
	import capability_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register access port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Back channel capability reports, one per port
	input wire logic [PORT_COUNT-1:0] rx_lock,
	input wire logic [PORT_COUNT-1:0] bc_valid,
	input wire logic [PORT_COUNT-1:0][BC_WIDTH-1:0] bc_cap1,
	input wire logic [PORT_COUNT-1:0][CAP2_WIDTH-1:0] bc_cap2,
	// Capability flags to the serializer, one per port
	output logic [PORT_COUNT-1:0] capability_freeze,
	output logic [PORT_COUNT-1:0][MODE_WIDTH-1:0] high_speed_channel_mode_code,
	output logic [PORT_COUNT-1:0] request_frequency_training,
	output logic [PORT_COUNT-1:0] request_equalization_training,
	output logic [PORT_COUNT-1:0] two_lane_capable,
	output logic [PORT_COUNT-1:0] channel_role,
	// Port selection state
	output logic second_port_select
);

	logic [SELECT_WIDTH-1:0] port_select;
	logic [SELECT_WIDTH-1:0] next_port_select;
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic [CAP1_WIDTH-1:0] cap1_all [PORT_COUNT];
	logic [CAP2_WIDTH-1:0] cap2_all [PORT_COUNT];
	logic sel;

	assign sel = port_select[SECOND_PORT_BIT];
	assign second_port_select = sel;

	// ----------------------------------------
	// Per-port capability stores
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < PORT_COUNT; i++)
		begin : g_port
			cap_if link ();

			// Writes go only to the copy picked by the select bit
			assign link.wr1 = reg_wr && (reg_addr == CAP1_ADDR) && (sel == 1'(i)); // [R9] [R10]
			assign link.wr2 = reg_wr && (reg_addr == CAP2_ADDR) && (sel == 1'(i)); // [R9] [R10]
			assign link.wdata = reg_wdata;
			// Back channel counts only once the receiver is locked
			assign link.bc_load = rx_lock[i] && bc_valid[i]; // [R3]
			assign link.bc_cap1 = bc_cap1[i];
			assign link.bc_cap2 = bc_cap2[i];

			capability_store u_store (
				.core_clk(core_clk),
				.rst(rst),
				.link(link)
			);

			// Stored flags leave straight from the store flip-flops
			assign cap1_all[i] = link.cap1;
			assign cap2_all[i] = link.cap2;
			assign capability_freeze[i] = link.cap1[FREEZE_BIT]; // [R1]
			assign high_speed_channel_mode_code[i] = {link.cap2, link.cap1[MODE_LOW_BIT]}; // [R2]
			assign request_frequency_training[i] = link.cap1[FREQ_BIT]; // [R5]
			assign request_equalization_training[i] = link.cap1[EQ_BIT]; // [R6]
			assign two_lane_capable[i] = link.cap1[TWO_LANE_BIT]; // [R7]
			assign channel_role[i] = link.cap1[ROLE_BIT]; // [R8]
		end
	endgenerate

	// ----------------------------------------
	// Port select register and read path
	// ----------------------------------------
	// Next select value and read answer
	always_comb
	begin
		next_port_select = port_select;
		next_rvalid = reg_rd;
		next_rdata = UNMAPPED_DATA;
		if (reg_wr && (reg_addr == PORT_SELECT_ADDR))
			next_port_select = reg_wdata[SELECT_WIDTH-1:0];
		if (reg_rd)
		begin
			if (reg_addr == PORT_SELECT_ADDR)
				next_rdata = {SELECT_PAD, port_select};
			else if (reg_addr == CAP1_ADDR)
				next_rdata = cap1_all[sel]; // [R9] [R10] [R11]
			else if (reg_addr == CAP2_ADDR)
				next_rdata = {CAP2_PAD, cap2_all[sel]}; // [R2] [R11]
			else
				next_rdata = UNMAPPED_DATA;
		end
	end

	// Register select, read data and read valid
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			port_select <= SELECT_RESET;
			reg_rdata <= UNMAPPED_DATA;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			port_select <= next_port_select;
			reg_rdata <= next_rdata;
			reg_rvalid <= next_rvalid;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_read_current_value: assert property ( // [R11]
		@(posedge core_clk) disable iff (rst)
		(reg_rd && (reg_addr == CAP1_ADDR))
		|=> reg_rvalid && (reg_rdata == $past(cap1_all[sel])))
		else $error("Capability read returned stale value");

	a_second_port_write: assert property ( // [R9]
		@(posedge core_clk) disable iff (rst)
		(reg_wr && (reg_addr == CAP1_ADDR) && sel && !bc_valid[0])
		|=> (cap1_all[1] == $past(reg_wdata)) && (cap1_all[0] == $past(cap1_all[0])))
		else $error("Second port select did not route the write");

	a_second_port_read: assert property ( // [R9]
		@(posedge core_clk) disable iff (rst)
		(reg_rd && (reg_addr == CAP1_ADDR) && sel)
		|=> reg_rdata == $past(cap1_all[1]))
		else $error("Set select did not read the second port");

	a_select_write: assert property ( // [R10]
		@(posedge core_clk) disable iff (rst)
		(reg_wr && (reg_addr == PORT_SELECT_ADDR))
		|=> second_port_select == $past(reg_wdata[SECOND_PORT_BIT]))
		else $error("Port select bit not stored");

	a_select_read: assert property ( // [R10]
		@(posedge core_clk) disable iff (rst)
		(reg_rd && (reg_addr == PORT_SELECT_ADDR))
		|=> reg_rdata == {SELECT_PAD, $past(port_select)})
		else $error("Port select read wrong");

	a_upper_mode_read: assert property ( // [R2]
		@(posedge core_clk) disable iff (rst)
		(reg_rd && (reg_addr == CAP2_ADDR))
		|=> reg_rdata == {CAP2_PAD, $past(cap2_all[sel])})
		else $error("Upper mode bits read wrong");

	a_rvalid_idle: assert property (
		@(posedge core_clk) disable iff (rst)
		!reg_rd |=> !reg_rvalid)
		else $error("Read valid without a read");

	a_first_port_read: assert property ( // [R10]
		@(posedge core_clk) disable iff (rst)
		(reg_rd && (reg_addr == CAP1_ADDR) && !sel)
		|=> reg_rdata == $past(cap1_all[0]))
		else $error("Cleared select did not read the first port");

	a_mode_code_out: assert property ( // [R2]
		@(posedge core_clk) disable iff (rst)
		(reg_wr && !sel && !bc_valid[0]
			&& ((reg_addr == CAP1_ADDR) || (reg_addr == CAP2_ADDR)))
		|=> high_speed_channel_mode_code[0] == ($past(reg_addr == CAP2_ADDR)
			? {$past(reg_wdata[CAP2_WIDTH-1:0]), $past(cap1_all[0][MODE_LOW_BIT])}
			: {$past(cap2_all[0]), $past(reg_wdata[MODE_LOW_BIT])}))
		else $error("Mode code not assembled from both registers");

	a_training_flags: assert property ( // [R5]
		@(posedge core_clk) disable iff (rst)
		(reg_wr && (reg_addr == CAP1_ADDR) && !sel)
		|=> (request_frequency_training[0] == $past(reg_wdata[FREQ_BIT]))
			&& (request_equalization_training[0] == $past(reg_wdata[EQ_BIT]))) // [R6]
		else $error("Training request flags wrong");

	a_lane_and_role: assert property ( // [R7]
		@(posedge core_clk) disable iff (rst)
		(rx_lock[1] && bc_valid[1] && !capability_freeze[1]
			&& !(reg_wr && (reg_addr == CAP1_ADDR) && sel))
		|=> (two_lane_capable[1] == $past(bc_cap1[1][TWO_LANE_BIT]))
			&& (channel_role[1] == $past(bc_cap1[1][ROLE_BIT]))) // [R8]
		else $error("Lane capability or role not loaded");

	a_no_load_unlocked: assert property ( // [R3]
		@(posedge core_clk) disable iff (rst)
		(!rx_lock[0] && !(reg_wr && ((reg_addr == CAP1_ADDR) || (reg_addr == CAP2_ADDR)) && !sel))
		|=> $stable(cap1_all[0]) && $stable(cap2_all[0]))
		else $error("Flags changed without lock or write");

	a_frozen_port_holds: assert property ( // [R1]
		@(posedge core_clk) disable iff (rst)
		(capability_freeze[1] && !(reg_wr && sel))
		|=> $stable(cap1_all[1]) && $stable(cap2_all[1]))
		else $error("Frozen port flags changed");

	a_unmapped_read: assert property (
		@(posedge core_clk) disable iff (rst)
		(reg_rd && (reg_addr != CAP1_ADDR) && (reg_addr != CAP2_ADDR)
			&& (reg_addr != PORT_SELECT_ADDR))
		|=> reg_rvalid && (reg_rdata == UNMAPPED_DATA))
		else $error("Unmapped read not zero");

endmodule

// File: bench/back_channel_model.sv
// Behavioural far-end receiver sending capability reports over the back channel
`timescale 1ns/100ps
module back_channel_model
	import capability_pkg::*;
(
	// Back channel toward the register bank
	output logic [PORT_COUNT-1:0] rx_lock,
	output logic [PORT_COUNT-1:0] bc_valid,
	output logic [PORT_COUNT-1:0][BC_WIDTH-1:0] bc_cap1,
	output logic [PORT_COUNT-1:0][CAP2_WIDTH-1:0] bc_cap2,
	// Clock
	input wire logic core_clk
);
	// Idle: no lock, report lines show a pattern that is not a valid image
	initial
	begin
		rx_lock = '0;
		bc_valid = '0;
		bc_cap1 = '1;
		bc_cap2 = '1;
	end

	// Lock level of one port
	task automatic set_lock(input int p, input logic lvl);
		@(posedge core_clk);
		#1 rx_lock[p] = lvl;
	endtask

	// One report pulse; afterwards the lines carry the inverse image
	task automatic report(input int p, input logic [6:0] c1, input logic [1:0] c2);
		@(posedge core_clk);
		#1 bc_valid[p] = 1'b1;
		bc_cap1[p] = c1;
		bc_cap2[p] = c2;
		@(posedge core_clk);
		#1 bc_valid[p] = 1'b0;
		bc_cap1[p] = ~c1;
		bc_cap2[p] = ~c2;
	endtask
endmodule

// File: bench/far_end_capability_register_tb.sv
// Self-checking bench for the far-end capability register bank
`timescale 1ns/100ps
`define CHECK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s expected %h seen %h", n, e, g); end end
module far_end_capability_register_tb;
	import capability_pkg::*;
	logic core_clk = 1'b0;
	logic rst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [1:0] rx_lock;
	logic [1:0] bc_valid;
	logic [1:0][6:0] bc_cap1;
	logic [1:0][1:0] bc_cap2;
	logic [1:0] frz;
	logic [1:0][2:0] mode;
	logic [1:0] freq;
	logic [1:0] eq;
	logic [1:0] lanes;
	logic [1:0] role;
	logic sel;
	int err_count = 0;
	int comparisons = 0;

	// Clock of 50 ns
	always #25 core_clk = ~core_clk;

	far_end_capability_register DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .rx_lock(rx_lock), .bc_valid(bc_valid), .bc_cap1(bc_cap1),
		.bc_cap2(bc_cap2), .capability_freeze(frz), .high_speed_channel_mode_code(mode),
		.request_frequency_training(freq), .request_equalization_training(eq),
		.two_lane_capable(lanes), .channel_role(role), .second_port_select(sel));

	back_channel_model far (.rx_lock(rx_lock), .bc_valid(bc_valid), .bc_cap1(bc_cap1),
		.bc_cap2(bc_cap2), .core_clk(core_clk));

	// ----------------------------------------
	// Access and compare helpers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1 reg_wr = 1'b0;
	endtask

	// Read strobe, answer expected one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk);
		#1 reg_rd = 1'b0;
		`CHECK("rvalid", 1'b1, reg_rvalid)
		`CHECK("rdata", e, reg_rdata)
	endtask

	// Flag outputs of port p against the two register images
	task automatic port(input int p, input logic [7:0] c1, input logic [1:0] c2);
		`CHECK("freeze", c1[7], frz[p])
		`CHECK("mode", {c2, c1[6]}, mode[p])
		`CHECK("freq", c1[5], freq[p])
		`CHECK("eq", c1[4], eq[p])
		`CHECK("lanes", c1[3], lanes[p])
		`CHECK("role", c1[2], role[p])
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic sc_reset;
		rd(CAP1_ADDR, 8'h00);
		rd(CAP2_ADDR, 8'h00);
		rd(PORT_SELECT_ADDR, 8'h01);
		port(0, 8'h00, 2'h0);
		port(1, 8'h00, 2'h0);
	endtask

	// Locked reports load every field but freeze; port 1 stays untouched
	task automatic sc_load;
		far.set_lock(0, 1'b1);
		far.report(0, 7'h6c, 2'h2);
		port(0, 8'h6c, 2'h2);
		far.report(0, 7'h13, 2'h1);
		rd(CAP1_ADDR, 8'h13);
		rd(CAP2_ADDR, 8'h01);
		port(0, 8'h13, 2'h1);
		port(1, 8'h00, 2'h0);
		far.set_lock(0, 1'b0);
		far.report(0, 7'h7f, 2'h3);
		port(0, 8'h13, 2'h1);
	endtask

	// Software values with freeze survive a locked report
	task automatic sc_freeze;
		wr(CAP1_ADDR, 8'hac);
		wr(CAP2_ADDR, 8'h02);
		far.set_lock(0, 1'b1);
		far.report(0, 7'h13, 2'h1);
		rd(CAP1_ADDR, 8'hac);
		rd(CAP2_ADDR, 8'h02);
		port(0, 8'hac, 2'h2);
		wr(CAP1_ADDR, 8'h00);
		far.report(0, 7'h55, 2'h3);
		port(0, 8'h55, 2'h3);
	endtask

	// Second port copy reached only through the select bit
	task automatic sc_second;
		wr(PORT_SELECT_ADDR, 8'h02);
		`CHECK("select", 1'b1, sel)
		rd(PORT_SELECT_ADDR, 8'h02);
		far.set_lock(1, 1'b1);
		far.report(1, 7'h2a, 2'h3);
		rd(CAP1_ADDR, 8'h2a);
		rd(CAP2_ADDR, 8'h03);
		wr(CAP1_ADDR, 8'h84);
		port(1, 8'h84, 2'h3);
		port(0, 8'h55, 2'h3);
		wr(PORT_SELECT_ADDR, 8'h00);
		rd(CAP1_ADDR, 8'h55);
		wr(8'h22, 8'hff);
		port(0, 8'h55, 2'h3);
		rd(8'h22, 8'h00);
	endtask

	// Reset, then every scenario in turn
	initial
	begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (10) @(posedge core_clk);
		#1 rst = 1'b0;
		sc_reset();
		sc_load();
		sc_freeze();
		sc_second();
		tally_and_finish();
	end
endmodule
